// ---- inc/wdg_pkg.sv ----
// Notes on behaviour
// - Once started, the count advances on each tick of the selected watchdog clock.
// - A count overflow issues a watchdog reset to the whole chip.
// - Writing 55H through the clear path while running zeroes the count.
// - A watchdog reset sets the reset-detection flag, bit 7 of control.
// - After a watchdog reset execution resumes at 0000H, or option address.
// - Standby select 1 or 2 stops counting in deep sleep; 0 or 3 keep running.
// - Standby select 2: standby stops the RC clock and freezes the count.
// - Leaving frozen standby restarts the RC clock and counting from the kept value.
// - Clock select 0 picks the low-speed RC clock, 1 picks the subclock.
// - Subclock mode: subclock stop or deep sleep forces a watchdog reset and flag.
// - Overflow when the count reaches 1024 shifted left by the three-bit select.
// - While running, ordinary control writes are ignored; clear and reads still work.
// - Standby entry with select 1 stops the watchdog and clears its run bit.
// - Watchdog reset keeps clock, standby and overflow selects; other resets clear all.
package wdg_pkg;

  // ==========================================================================
  // Register map and values
  localparam logic [7:0]  WDG_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  WDG_OFF_CLEAR   = 8'h04;
  localparam logic [7:0]  WDG_OFF_STAT    = 8'h08;
  localparam logic [7:0]  WDG_OFF_MASK    = 8'h0C;
  localparam logic [7:0]  WDG_OFF_COUNT   = 8'h10;
  localparam logic [7:0]  WDG_CLEAR_KEY   = 8'h55;
  localparam logic [7:0]  WDG_CTRL_RESET  = 8'h00;
  localparam logic [2:0]  WDG_STAT_RESET  = 3'h0;
  localparam logic [15:0] WDG_RESUME_ADDR = 16'h0000;

  // ==========================================================================
  // Counter
  localparam int          WDG_CNT_W       = 18;
  localparam logic [17:0] WDG_BASE_LIMIT  = 18'h00400;
  localparam logic [17:0] WDG_CNT_ONE     = 18'h00001;
  localparam logic [17:0] WDG_CNT_ZERO    = 18'h00000;

  // ==========================================================================
  // Standby operation select codes
  localparam logic [1:0]  WDG_SB_CONT0    = 2'h0;
  localparam logic [1:0]  WDG_SB_STOP     = 2'h1;
  localparam logic [1:0]  WDG_SB_FREEZE   = 2'h2;
  localparam logic [1:0]  WDG_SB_CONT3    = 2'h3;

  // Control register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic       resetFlag;
    logic       clockSelect;
    logic       runBit;
    logic [1:0] standbySel;
    logic [2:0] overflowSel;
  } wdg_ctrl_t;

  // Event bits of the sticky status and mask registers.
  typedef struct packed {
    logic standbyStop;
    logic clockLoss;
    logic overflow;
  } wdg_evt_t;

  typedef enum logic [2:0] {
    WDG_ST_STOP   = 3'b001,
    WDG_ST_RUN    = 3'b010,
    WDG_ST_FROZEN = 3'b100
  } wdg_state_t;

  // Overflow count for a select code.
  function automatic logic [17:0] wdg_limit(input logic [2:0] sel);
    wdg_limit = WDG_BASE_LIMIT << sel;
  endfunction : wdg_limit

endpackage : wdg_pkg

// ---- rtl/wdg_tick.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdg_tick
  import wdg_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic oscLevel,
  output logic      tick
);

  // ==========================================================================
  // Edge detector
  logic prevLevel;
  logic next_prevLevel;
  logic next_tick;

  // A rising edge of the oscillator level becomes one enable pulse.
  always_comb
  begin
    next_prevLevel = oscLevel;
    next_tick      = oscLevel & ~prevLevel;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prevLevel <= 1'b0;
      tick      <= 1'b0;
    end
    else
    begin
      prevLevel <= next_prevLevel;
      tick      <= next_tick;
    end
  end

endmodule : wdg_tick
`default_nettype wire

// ---- rtl/wdg_watchdog.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdg_watchdog
  import wdg_pkg::*;
#(
  parameter logic        FLASH_VARIANT = 1'b0,
  parameter logic [15:0] OPTION_ADDR   = 16'h0000
)
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rcOscLevel,
  input  wire logic        subOscLevel,
  input  wire logic        subclockOscEnable,
  input  wire logic        standbyMode,
  input  wire logic        deepSleepMode,
  output logic             chipReset,
  output logic             rcOscRun,
  output logic      [15:0] resumeAddr,
  output logic             irq
);

  // ==========================================================================
  // State
  wdg_state_t           state;
  wdg_state_t           next_state;
  wdg_ctrl_t            ctrl;
  wdg_ctrl_t            next_ctrl;
  wdg_evt_t             stat;
  wdg_evt_t             next_stat;
  wdg_evt_t             mask;
  wdg_evt_t             next_mask;
  wdg_evt_t             events;
  logic [WDG_CNT_W-1:0] count;
  logic [WDG_CNT_W-1:0] next_count;
  logic [WDG_CNT_W-1:0] countPlus;
  logic                 clearPending;
  logic                 next_clearPending;
  logic                 standbyPrev;
  logic                 wdTick;
  logic                 oscSel;
  logic                 setup;
  logic                 access;
  logic                 wrCtrl;
  logic                 wrClear;
  logic                 wrStat;
  logic                 wrMask;
  logic                 mapped;
  logic                 running;
  logic                 standbyEntry;
  logic                 sleepHold;
  logic                 freezeCond;
  logic                 overflow;
  logic                 clockLoss;
  logic                 standbyStop;
  logic                 wdReset;
  logic [31:0]          readMux;
  logic [31:0]          next_prdata;
  logic                 next_pready;
  logic                 next_pslverr;
  logic                 next_irq;
  logic                 next_rcOscRun;
  wdg_ctrl_t            ctrlView;

  // ==========================================================================
  // Count clock source
  // A source switch may cause one spurious edge; software only switches while stopped,
  // but a write that also sets the run bit can count that edge once.
  assign oscSel = ctrl.clockSelect ? subOscLevel : rcOscLevel;

  wdg_tick wdg_tick_inst (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .oscLevel (oscSel),
    .tick     (wdTick)
  );

  // ==========================================================================
  // APB decode
  // Zero-wait reads are impossible with registered outputs, so every
  // access completes in its first access cycle after a registered setup.
  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready;
  assign mapped  = (paddr == WDG_OFF_CTRL) || (paddr == WDG_OFF_CLEAR) ||
                   (paddr == WDG_OFF_STAT) || (paddr == WDG_OFF_MASK) ||
                   (paddr == WDG_OFF_COUNT);
  assign wrCtrl  = access & pwrite & (paddr == WDG_OFF_CTRL);
  assign wrClear = access & pwrite & (paddr == WDG_OFF_CLEAR);
  assign wrStat  = access & pwrite & (paddr == WDG_OFF_STAT);
  assign wrMask  = access & pwrite & (paddr == WDG_OFF_MASK);

  // ==========================================================================
  // Watchdog conditions
  // Run bit as software sees it follows the state machine.
  always_comb
  begin
    ctrlView        = ctrl;
    ctrlView.runBit = running;
  end

  assign running      = (state != WDG_ST_STOP);
  assign standbyEntry = standbyMode & ~standbyPrev;
  assign sleepHold    = deepSleepMode &&
                        ((ctrl.standbySel == WDG_SB_STOP) ||
                         (ctrl.standbySel == WDG_SB_FREEZE));
  assign freezeCond   = standbyMode && (ctrl.standbySel == WDG_SB_FREEZE);
  assign countPlus    = count + WDG_CNT_ONE;
  assign overflow     = (state == WDG_ST_RUN) && wdTick && !sleepHold && !clearPending &&
                        (countPlus == wdg_limit(ctrl.overflowSel));
  assign clockLoss    = running && ctrl.clockSelect &&
                        (!subclockOscEnable || deepSleepMode);
  assign wdReset      = overflow | clockLoss;
  assign standbyStop  = (state == WDG_ST_RUN) && !wdReset && standbyEntry &&
                        (ctrl.standbySel == WDG_SB_STOP);

  always_comb
  begin
    events             = '0;
    events.overflow    = overflow;
    events.clockLoss   = clockLoss;
    events.standbyStop = standbyStop;
  end

  // ==========================================================================
  // Next state of the watchdog core
  always_comb
  begin
    next_state        = state;
    next_ctrl         = ctrl;
    next_count        = count;
    // The clear is registered once so it meets the counter a cycle later.
    next_clearPending = wrClear && running && (pwdata[7:0] == WDG_CLEAR_KEY);
    case (state)
      WDG_ST_STOP:
      begin
        if (wrCtrl && pwdata[5])
        begin
          next_state = WDG_ST_RUN;
        end
      end
      WDG_ST_RUN:
      begin
        if (wdReset)
        begin
          next_state = WDG_ST_STOP;
        end
        else if (standbyStop)
        begin
          next_state = WDG_ST_STOP;
        end
        else if (freezeCond)
        begin
          next_state = WDG_ST_FROZEN;
        end
      end
      WDG_ST_FROZEN:
      begin
        if (wdReset)
        begin
          next_state = WDG_ST_STOP;
        end
        else if (!standbyMode)
        begin
          next_state = WDG_ST_RUN;
        end
      end
      default:
      begin
        next_state = WDG_ST_STOP;
      end
    endcase
    // Ordinary control writes land only while stopped.
    if (wrCtrl && !running)
    begin
      next_ctrl        = pwdata[7:0];
      next_ctrl.runBit = 1'b0;
    end
    // The flag set beats a same-cycle software write; selects are kept.
    if (wdReset)
    begin
      next_ctrl.resetFlag = 1'b1;
    end
    if (wdReset || (next_state == WDG_ST_STOP))
    begin
      next_count = WDG_CNT_ZERO;
    end
    else if (clearPending)
    begin
      next_count = WDG_CNT_ZERO;
    end
    else if ((state == WDG_ST_RUN) && wdTick && !sleepHold)
    begin
      next_count = countPlus;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state        <= WDG_ST_STOP;
      ctrl         <= WDG_CTRL_RESET;
      count        <= WDG_CNT_ZERO;
      clearPending <= 1'b0;
      standbyPrev  <= 1'b0;
    end
    else
    begin
      state        <= next_state;
      ctrl         <= next_ctrl;
      count        <= next_count;
      clearPending <= next_clearPending;
      standbyPrev  <= standbyMode;
    end
  end

  // ==========================================================================
  // Interrupt status, mask and chip-level outputs
  // Set wins over a write-one clear in the same cycle.
  always_comb
  begin
    next_stat     = (stat & ~(wrStat ? wdg_evt_t'(pwdata[2:0]) : wdg_evt_t'(3'h0))) | events;
    next_mask     = wrMask ? wdg_evt_t'(pwdata[2:0]) : mask;
    next_irq      = |(stat & mask);
    next_rcOscRun = running && !ctrl.clockSelect && (state != WDG_ST_FROZEN);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stat       <= WDG_STAT_RESET;
      mask       <= WDG_STAT_RESET;
      irq        <= 1'b0;
      rcOscRun   <= 1'b0;
      chipReset  <= 1'b0;
      resumeAddr <= FLASH_VARIANT ? OPTION_ADDR : WDG_RESUME_ADDR;
    end
    else
    begin
      stat       <= next_stat;
      mask       <= next_mask;
      irq        <= next_irq;
      rcOscRun   <= next_rcOscRun;
      chipReset  <= wdReset;
      resumeAddr <= FLASH_VARIANT ? OPTION_ADDR : WDG_RESUME_ADDR;
    end
  end

  // ==========================================================================
  // APB read path and completion
  always_comb
  begin
    readMux = 32'h00000000;
    case (paddr)
      WDG_OFF_CTRL:  readMux[7:0] = ctrlView;
      WDG_OFF_STAT:  readMux[2:0] = stat;
      WDG_OFF_MASK:  readMux[2:0] = mask;
      WDG_OFF_COUNT: readMux[WDG_CNT_W-1:0] = count;
      default:       readMux = 32'h00000000;
    endcase
    next_pready  = setup;
    next_pslverr = setup && !mapped;
    next_prdata  = (setup && !pwrite) ? readMux : 32'h00000000;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

endmodule : wdg_watchdog
`default_nettype wire

// ---- tb/wdg_watchdog_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdg_watchdog_sva
  import wdg_pkg::*;
#(
  parameter logic        FLASH_VARIANT = 1'b0,
  parameter logic [15:0] OPTION_ADDR   = 16'h0000
)
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        chipReset,
  input wire logic [15:0] resumeAddr
);
  // ==========================================================================
  // Bus timing and reset output checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // The slave always answers in the first access cycle, never later.
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_unmapped: assert property (psel && !penable && paddr > WDG_OFF_COUNT |=> pslverr)
    else $error("no error for unmapped address");
  a_err_mapped: assert property (psel && !penable && paddr[1:0] == 2'h0
    && paddr <= WDG_OFF_COUNT |=> !pslverr)
    else $error("error for mapped address");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_reset_pulse: assert property (chipReset |=> !chipReset)
    else $error("chip reset longer than one cycle");
  a_resume_fixed: assert property (resumeAddr == (FLASH_VARIANT ? OPTION_ADDR
    : WDG_RESUME_ADDR))
    else $error("wrong resume address");
endmodule : wdg_watchdog_sva

bind wdg_watchdog wdg_watchdog_sva #(.FLASH_VARIANT(FLASH_VARIANT), .OPTION_ADDR(OPTION_ADDR))
  wdg_watchdog_sva_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chipReset(chipReset), .resumeAddr(resumeAddr));
`default_nettype wire

// ---- tb/wdg_watchdog_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module wdg_watchdog_tb
  import wdg_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        osc = 1'b0;
  logic        subEn = 1'b0;
  logic        sb = 1'b0;
  logic        ds = 1'b0;
  logic        chipReset;
  logic        rcOscRun;
  logic        irq;
  int          badCount = 0;
  int          samplesChecked = 0;
  int          resets = 0;

  wdg_watchdog wdg_watchdog_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rcOscLevel(osc), .subOscLevel(osc),
    .subclockOscEnable(subEn), .standbyMode(sb), .deepSleepMode(ds),
    .chipReset(chipReset), .rcOscRun(rcOscRun), .resumeAddr(), .irq(irq));

  // ==========================================================================
  // Clock and watchdog reset pulse counter
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (chipReset === 1'b1) resets++;

  task automatic results;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      badCount++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // One APB transfer; the request stays put until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    int i;
    i = 0;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Values read right at the edge are the ones that stood before it.
    do
    begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      badCount++;
      results();
    end
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask : rd

  // Each tick is one rising edge of the oscillator level, slow enough to sync.
  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge core_clk) osc <= 1'b1;
      repeat (2) @(posedge core_clk);
      osc <= 1'b0;
      repeat (2) @(posedge core_clk);
    end
  endtask : tick

  task automatic do_reset;
    @(posedge core_clk) reset_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // ==========================================================================
  // Scenarios
  task automatic s_overflow;
    logic [31:0] r;
    logic        e;
    rd(WDG_OFF_CTRL, 32'h0, "ctrl reset");
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    wr(WDG_OFF_MASK, 32'h1);
    wr(WDG_OFF_CTRL, 32'h20);
    tick(1023);
    chk("early reset", 32'h0, resets);
    tick(1);
    repeat (4) @(posedge core_clk);
    chk("overflow reset", 32'h1, resets);
    rd(WDG_OFF_CTRL, 32'h80, "ctrl after overflow");
    chk("irq set", 32'h1, {31'h0, irq});
    wr(WDG_OFF_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : s_overflow

  task automatic s_clear_stop;
    wr(WDG_OFF_CTRL, 32'h2B);
    tick(100);
    rd(WDG_OFF_COUNT, 32'd100, "count ticks");
    wr(WDG_OFF_CTRL, 32'h2F);
    rd(WDG_OFF_CTRL, 32'h2B, "write ignored");
    wr(WDG_OFF_CLEAR, 32'h55);
    rd(WDG_OFF_COUNT, 32'h0, "count cleared");
    @(posedge core_clk) sb <= 1'b1;
    repeat (3) @(posedge core_clk);
    sb <= 1'b0;
    rd(WDG_OFF_CTRL, 32'h0B, "standby stop");
  endtask : s_clear_stop

  task automatic s_freeze;
    wr(WDG_OFF_CTRL, 32'h30);
    tick(5);
    chk("rc on", 32'h1, {31'h0, rcOscRun});
    @(posedge core_clk) sb <= 1'b1;
    // State moves one edge after standby, the oscillator request one more.
    repeat (3) @(posedge core_clk);
    chk("rc stopped", 32'h0, {31'h0, rcOscRun});
    tick(5);
    rd(WDG_OFF_COUNT, 32'd5, "count frozen");
    @(posedge core_clk) sb <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("rc restart", 32'h1, {31'h0, rcOscRun});
    tick(4);
    rd(WDG_OFF_COUNT, 32'd9, "count resumed");
    do_reset();
    rd(WDG_OFF_CTRL, 32'h0, "ctrl ext reset");
  endtask : s_freeze

  task automatic s_loss;
    @(posedge core_clk) subEn <= 1'b1;
    wr(WDG_OFF_CTRL, 32'h60);
    tick(3);
    @(posedge core_clk) subEn <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("loss reset", 32'h2, resets);
    rd(WDG_OFF_CTRL, 32'hC0, "ctrl after loss");
  endtask : s_loss

  // Deep sleep holds the count with stop select, and is fatal in subclock mode.
  task automatic s_sleep;
    wr(WDG_OFF_CTRL, 32'h28);
    tick(2);
    @(posedge core_clk) ds <= 1'b1;
    tick(3);
    rd(WDG_OFF_COUNT, 32'd2, "sleep hold");
    @(posedge core_clk) ds <= 1'b0;
    tick(1);
    rd(WDG_OFF_COUNT, 32'd3, "sleep resume");
    @(posedge core_clk) sb <= 1'b1;
    @(posedge core_clk) sb <= 1'b0;
    @(posedge core_clk) subEn <= 1'b1;
    wr(WDG_OFF_CTRL, 32'h60);
    tick(1);
    @(posedge core_clk) ds <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("sleep loss reset", 32'h3, resets);
    @(posedge core_clk) ds <= 1'b0;
  endtask : s_sleep

  initial
  begin
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    s_overflow();
    s_clear_stop();
    s_freeze();
    s_loss();
    s_sleep();
    results();
  end
endmodule : wdg_watchdog_tb
`default_nettype wire
